/* verilog/tpu_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module tpu_ctl (
   input  wire logic                            mclk,
   input  wire logic                            nrst,
   input  wire tpu_pkg::tpu_req_s               bus_req,
   output logic      [15:0]                     bus_rdata_q,
   output logic                                 bus_ack_q,
   output logic                                 bus_busy_q,
   output logic      [tpu_pkg::NUM_CH-1:0]      run_q,
   output logic      [tpu_pkg::NUM_CH-1:0][15:0] count_q,
   output logic      [tpu_pkg::NUM_CH-1:0][15:0] gr_q,
   output logic      [tpu_pkg::NUM_CH-1:0][15:0] dr_q,
   output logic                                 ch1_pwm_q,
   output logic                                 ch2_pwm_q,
   output logic      [tpu_pkg::OE_CH1_W-1:0]    ch1_oe_q,
   output logic      [tpu_pkg::OE_CH2_W-1:0]    ch2_oe_q
);

   logic [7:0]                       breg_q [tpu_pkg::NUM_BREG];
   logic [7:0]                       breg_d [tpu_pkg::NUM_BREG];
   logic [tpu_pkg::NUM_CH-1:0][15:0] gr_d;
   logic [tpu_pkg::NUM_CH-1:0][15:0] dr_d;
   tpu_pkg::tpu_state_e              state_q;
   tpu_pkg::tpu_state_e              state_d;
   logic [7:0]                       ph_addr_q;
   logic [7:0]                       ph_addr_d;
   logic [7:0]                       ph_data_q;
   logic [7:0]                       ph_data_d;
   logic                             ph_we_q;
   logic                             ph_we_d;
   logic [15:0]                      rdata_d;
   logic                             ack_d;
   logic                             ch1_pwm_d;
   logic                             ch2_pwm_d;
   logic [tpu_pkg::OE_CH1_W-1:0]     ch1_oe_d;
   logic [tpu_pkg::OE_CH2_W-1:0]     ch2_oe_d;
   logic [tpu_pkg::NUM_CH-1:0]       cnt_wr_hi;
   logic [tpu_pkg::NUM_CH-1:0]       cnt_wr_lo;
   logic [15:0]                      cnt_wdata;
   logic                             op_valid;
   logic                             op_we;
   logic                             op_word16;
   logic [7:0]                       op_addr;
   logic [15:0]                      op_wdata;

   function automatic logic is_breg(input logic [7:0] a);
      return a < 8'(tpu_pkg::NUM_BREG);
   endfunction

   function automatic logic in_words(input logic [7:0] a,
                                     input logic [7:0] base);
      return (a >= base) && (a < base + tpu_pkg::WORD_SPAN);
   endfunction

   function automatic int word_idx(input logic [7:0] a,
                                   input logic [7:0] base);
      logic [7:0] diff;
      diff = a - base;
      return int'(diff[7:1]);
   endfunction

   function automatic logic [7:0] pick(input logic [15:0] w,
                                       input logic lo);
      return lo ? w[7:0] : w[15:8];
   endfunction

   // One byte of any register; unmapped addresses read as zero.
   function automatic logic [7:0] byte_read(input logic [7:0] a);
      logic [7:0] r;
      r = 8'h00;
      if (is_breg(a)) begin
         r = breg_q[a[3:0]];
         if (a == tpu_pkg::OFS_RUN) begin
            r = r | tpu_pkg::RUN_RSVD_MASK;
         end else if (a == tpu_pkg::OFS_MODE_B) begin
            r = r | tpu_pkg::MODE_B_RSVD_MASK;
         end
      end else if (in_words(a, tpu_pkg::OFS_CNT_BASE)) begin
         r = pick(count_q[word_idx(a, tpu_pkg::OFS_CNT_BASE)], a[0]);
      end else if (in_words(a, tpu_pkg::OFS_GR_BASE)) begin
         r = pick(gr_q[word_idx(a, tpu_pkg::OFS_GR_BASE)], a[0]);
      end else if (in_words(a, tpu_pkg::OFS_DR_BASE)) begin
         r = pick(dr_q[word_idx(a, tpu_pkg::OFS_DR_BASE)], a[0]);
      end
      return r;
   endfunction

   // Sequencing of bus requests into per-cycle operations.
   always_comb begin
      state_d   = state_q;
      ph_addr_d = ph_addr_q;
      ph_data_d = ph_data_q;
      ph_we_d   = ph_we_q;
      rdata_d   = bus_rdata_q;
      ack_d     = 1'b0;
      op_valid  = 1'b0;
      op_we     = 1'b0;
      op_word16 = 1'b0;
      op_addr   = 8'h00;
      op_wdata  = 16'h0000;
      case (state_q)
         tpu_pkg::TPU_IDLE: begin
            if (bus_req.req) begin
               op_valid = 1'b1;
               op_we    = bus_req.we;
               op_wdata = bus_req.wdata;
               if (bus_req.word && is_breg(bus_req.addr)) begin
                  // Byte registers only have an eight-bit path, so a word
                  // costs a second cycle for the odd lower byte.
                  op_addr   = {bus_req.addr[7:1], 1'b0};
                  op_wdata  = {8'h00, bus_req.wdata[15:8]};
                  ph_addr_d = {bus_req.addr[7:1], 1'b1};
                  ph_data_d = bus_req.wdata[7:0];
                  ph_we_d   = bus_req.we;
                  rdata_d   = {byte_read(op_addr), 8'h00};
                  state_d   = tpu_pkg::TPU_SECOND;
               end else if (bus_req.word) begin
                  op_word16 = 1'b1;
                  op_addr   = {bus_req.addr[7:1], 1'b0};
                  rdata_d   = {byte_read(op_addr),
                               byte_read({bus_req.addr[7:1], 1'b1})};
                  ack_d     = 1'b1;
               end else begin
                  op_addr = bus_req.addr;
                  rdata_d = {8'h00, byte_read(bus_req.addr)};
                  ack_d   = 1'b1;
               end
            end
         end
         tpu_pkg::TPU_SECOND: begin
            op_valid     = 1'b1;
            op_we        = ph_we_q;
            op_addr      = ph_addr_q;
            op_wdata     = {8'h00, ph_data_q};
            rdata_d[7:0] = byte_read(ph_addr_q);
            ack_d        = 1'b1;
            state_d      = tpu_pkg::TPU_IDLE;
         end
         default: begin
            state_d = tpu_pkg::TPU_IDLE;
         end
      endcase
   end

   // Register writes for the current operation.
   always_comb begin
      logic wr_hi;
      logic wr_lo;
      logic [15:0] wv;
      int idx;
      wr_hi = op_word16 || !op_addr[0];
      wr_lo = op_word16 || op_addr[0];
      wv    = op_word16 ? op_wdata : {op_wdata[7:0], op_wdata[7:0]};
      idx   = 0;
      for (int i = 0; i < tpu_pkg::NUM_BREG; i++) begin
         breg_d[i] = breg_q[i];
      end
      gr_d      = gr_q;
      dr_d      = dr_q;
      cnt_wr_hi = '0;
      cnt_wr_lo = '0;
      cnt_wdata = wv;
      if (op_valid && op_we) begin
         if (is_breg(op_addr)) begin
            breg_d[op_addr[3:0]] = op_wdata[7:0];
            if (op_addr == tpu_pkg::OFS_RUN) begin
               breg_d[op_addr[3:0]] = op_wdata[7:0] &
                                      ~tpu_pkg::RUN_RSVD_MASK;
            end
         end else if (in_words(op_addr, tpu_pkg::OFS_CNT_BASE)) begin
            idx = word_idx(op_addr, tpu_pkg::OFS_CNT_BASE);
            cnt_wr_hi[idx] = wr_hi;
            cnt_wr_lo[idx] = wr_lo;
         end else if (in_words(op_addr, tpu_pkg::OFS_GR_BASE)) begin
            idx = word_idx(op_addr, tpu_pkg::OFS_GR_BASE);
            if (wr_hi) begin
               gr_d[idx][15:8] = wv[15:8];
            end
            if (wr_lo) begin
               gr_d[idx][7:0] = wv[7:0];
            end
         end else if (in_words(op_addr, tpu_pkg::OFS_DR_BASE)) begin
            idx = word_idx(op_addr, tpu_pkg::OFS_DR_BASE);
            if (wr_hi) begin
               dr_d[idx][15:8] = wv[15:8];
            end
            if (wr_lo) begin
               dr_d[idx][7:0] = wv[7:0];
            end
         end
      end
   end

   // Mode outputs follow the next register value so channels see no lag.
   always_comb begin
      logic [7:0] mode_b;
      mode_b    = breg_d[tpu_pkg::OFS_MODE_B[3:0]];
      ch1_pwm_d = mode_b[tpu_pkg::PWM_CH1_BIT];
      ch2_pwm_d = mode_b[tpu_pkg::PWM_CH2_BIT];
      ch1_oe_d  = ch1_pwm_d ? '0 :
                  breg_d[tpu_pkg::OFS_OE_CH1[3:0]][tpu_pkg::OE_CH1_W-1:0];
      ch2_oe_d  = ch2_pwm_d ? '0 :
                  breg_d[tpu_pkg::OFS_OE_CH2[3:0]][tpu_pkg::OE_CH2_W-1:0];
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         for (int i = 0; i < tpu_pkg::NUM_BREG; i++) begin
            breg_q[i] <= tpu_pkg::BREG_RST;
         end
         gr_q        <= '0;
         dr_q        <= '0;
         state_q     <= tpu_pkg::TPU_IDLE;
         ph_addr_q   <= 8'h00;
         ph_data_q   <= 8'h00;
         ph_we_q     <= 1'b0;
         bus_rdata_q <= 16'h0000;
         bus_ack_q   <= 1'b0;
         bus_busy_q  <= 1'b0;
         run_q       <= '0;
         ch1_pwm_q   <= 1'b0;
         ch2_pwm_q   <= 1'b0;
         ch1_oe_q    <= '0;
         ch2_oe_q    <= '0;
      end else begin
         for (int i = 0; i < tpu_pkg::NUM_BREG; i++) begin
            breg_q[i] <= breg_d[i];
         end
         gr_q        <= gr_d;
         dr_q        <= dr_d;
         state_q     <= state_d;
         ph_addr_q   <= ph_addr_d;
         ph_data_q   <= ph_data_d;
         ph_we_q     <= ph_we_d;
         bus_rdata_q <= rdata_d;
         bus_ack_q   <= ack_d;
         bus_busy_q  <= (state_d == tpu_pkg::TPU_SECOND);
         run_q       <= breg_d[tpu_pkg::OFS_RUN[3:0]][tpu_pkg::NUM_CH-1:0];
         ch1_pwm_q   <= ch1_pwm_d;
         ch2_pwm_q   <= ch2_pwm_d;
         ch1_oe_q    <= ch1_oe_d;
         ch2_oe_q    <= ch2_oe_d;
      end
   end

   generate
      for (genvar c = 0; c < tpu_pkg::NUM_CH; c++) begin : g_cnt
         tpu_chan_cnt u_cnt (
            .mclk    (mclk),
            .nrst    (nrst),
            .run     (run_q[c]),
            .wr_hi   (cnt_wr_hi[c]),
            .wr_lo   (cnt_wr_lo[c]),
            .wdata   (cnt_wdata),
            .count_q (count_q[c])
         );
      end
   endgenerate

endmodule
`default_nettype wire

/* verilog/tpu_pkg.sv */
package tpu_pkg;

   localparam int NUM_CH = 7;
   localparam int NUM_BREG = 10;

   // Byte-wide register offsets; each even/odd pair forms one word.
   localparam logic [7:0] OFS_CTRL_HI   = 8'h00;
   localparam logic [7:0] OFS_CTRL_LO   = 8'h01;
   localparam logic [7:0] OFS_STAT_HI   = 8'h02;
   localparam logic [7:0] OFS_STAT_LO   = 8'h03;
   localparam logic [7:0] OFS_OE_CH1    = 8'h04;
   localparam logic [7:0] OFS_MODE_A    = 8'h05;
   localparam logic [7:0] OFS_OE_CH2    = 8'h06;
   localparam logic [7:0] OFS_MODE_B    = 8'h07;
   localparam logic [7:0] OFS_RUN       = 8'h08;
   localparam logic [7:0] OFS_CH1_CTL_B = 8'h09;

   // Word-wide register bases, one word per channel.
   localparam logic [7:0] OFS_CNT_BASE  = 8'h20;
   localparam logic [7:0] OFS_GR_BASE   = 8'h30;
   localparam logic [7:0] OFS_DR_BASE   = 8'h40;
   localparam logic [7:0] WORD_SPAN     = 8'h0E;

   localparam int PWM_CH1_BIT = 0;
   localparam int PWM_CH2_BIT = 1;
   localparam int OE_CH1_W = 6;
   localparam int OE_CH2_W = 4;

   localparam logic [7:0] RUN_RSVD_MASK    = 8'h80;
   localparam logic [7:0] MODE_B_RSVD_MASK = 8'hC0;
   localparam logic [7:0] BREG_RST         = 8'h00;
   localparam logic [15:0] WORD_RST        = 16'h0000;

   typedef enum logic [0:0] {
      TPU_IDLE   = 1'b0,
      TPU_SECOND = 1'b1
   } tpu_state_e;

   typedef struct packed {
      logic        req;
      logic        we;
      logic        word;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } tpu_req_s;

endpackage

/* verilog/tpu_chan_cnt.sv */
`timescale 1ns/1ps
`default_nettype none
module tpu_chan_cnt (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        run,
   input  wire logic        wr_hi,
   input  wire logic        wr_lo,
   input  wire logic [15:0] wdata,
   output logic      [15:0] count_q
);

   logic        run_prev_q;
   logic [15:0] count_d;

   always_comb begin
      count_d = count_q;
      if (run && !run_prev_q) begin
         count_d = tpu_pkg::WORD_RST;
      end else if (wr_hi || wr_lo) begin
         // A bus write wins over the increment so software sees its value.
         if (wr_hi) begin
            count_d[15:8] = wdata[15:8];
         end
         if (wr_lo) begin
            count_d[7:0] = wdata[7:0];
         end
      end else if (run) begin
         count_d = count_q + 16'h0001;
      end
      // Otherwise the value is held while halted.
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         count_q    <= tpu_pkg::WORD_RST;
         run_prev_q <= 1'b0;
      end else begin
         count_q    <= count_d;
         run_prev_q <= run;
      end
   end

endmodule
`default_nettype wire

/* tb/tpu_ctl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module tpu_ctl_assertions (
   input wire logic                             mclk,
   input wire logic                             nrst,
   input wire tpu_pkg::tpu_req_s                bus_req,
   input wire logic                             bus_ack_q,
   input wire logic                             bus_busy_q,
   input wire logic [tpu_pkg::NUM_CH-1:0]       run_q,
   input wire logic [tpu_pkg::NUM_CH-1:0][15:0] count_q,
   input wire logic                             ch1_pwm_q,
   input wire logic                             ch2_pwm_q,
   input wire logic [tpu_pkg::OE_CH1_W-1:0]     ch1_oe_q,
   input wire logic [tpu_pkg::OE_CH2_W-1:0]     ch2_oe_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic take;
   logic pair;
   logic bwr;
   assign take = bus_req.req && !bus_busy_q;
   assign pair = bus_req.word && (bus_req.addr < 8'h0A);
   assign bwr  = take && bus_req.we && !bus_req.word;
   AST_CH2_OE_OFF: assert property (ch2_pwm_q |-> ch2_oe_q == 4'h0)
      else $error("ch2 enables live in modulation mode");
   AST_CH1_OE_OFF: assert property (ch1_pwm_q |-> ch1_oe_q == 6'h00)
      else $error("ch1 enables live in modulation mode");
   AST_MODE_WR: assert property (bwr && bus_req.addr == 8'h07 |=>
      ch1_pwm_q == $past(bus_req.wdata[0]) &&
      ch2_pwm_q == $past(bus_req.wdata[1]))
      else $error("modulation select not taken from write");
   AST_RUN_BYTE: assert property (bwr && bus_req.addr == 8'h08 |=>
      run_q == $past(bus_req.wdata[6:0])) else $error("run bits wrong");
   AST_RUN_WORD: assert property (take && bus_req.we && pair &&
      bus_req.addr[7:1] == 7'h04 |=> run_q == $past(bus_req.wdata[14:8]))
      else $error("word write did not reach run bits");
   AST_PAIR_SEQ: assert property (take && pair |=>
      bus_busy_q && !bus_ack_q ##1 bus_ack_q && !bus_busy_q)
      else $error("paired byte access out of sequence");
   AST_SINGLE: assert property (take && !pair |=> bus_ack_q && !bus_busy_q)
      else $error("single access not answered next cycle");
   AST_RESTART: assert property ($rose(run_q[0]) |=> count_q[0] == 16'h0000)
      else $error("counter not cleared on start");
   AST_COUNT_UP: assert property (run_q[0] && $past(run_q[0]) &&
      $past(run_q[0], 2) && !bus_ack_q |->
      count_q[0] == $past(count_q[0]) + 16'h0001)
      else $error("running counter did not step by one");
   AST_HALT_HOLD: assert property (!run_q[0] && !$past(run_q[0]) &&
      !bus_ack_q |-> $stable(count_q[0])) else $error("halted counter moved");
   COV_START: cover property ($rose(run_q[0]));
   COV_PAIR: cover property (take && pair);
   COV_BOTH_PWM: cover property (ch1_pwm_q && ch2_pwm_q);
endmodule
bind tpu_ctl tpu_ctl_assertions u_chk (.mclk(mclk), .nrst(nrst),
   .bus_req(bus_req), .bus_ack_q(bus_ack_q), .bus_busy_q(bus_busy_q),
   .run_q(run_q), .count_q(count_q), .ch1_pwm_q(ch1_pwm_q),
   .ch2_pwm_q(ch2_pwm_q), .ch1_oe_q(ch1_oe_q), .ch2_oe_q(ch2_oe_q));
`default_nettype wire

/* tb/tpu_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tpu_cpu_model (
   input  wire logic             mclk,
   output var tpu_pkg::tpu_req_s bus_req,
   input  wire logic [15:0]      bus_rdata_q,
   input  wire logic             bus_ack_q
);
   initial bus_req = '0;
   // Released fields show inverted values so a stale sample cannot match.
   task automatic access(input logic we, input logic word,
         input logic [7:0] addr, input logic [15:0] wdata, input int gap,
         output logic [15:0] rdata, output logic ok);
      int n;
      n = 0;
      repeat (gap) @(negedge mclk);
      @(negedge mclk);
      bus_req <= '{req: 1'b1, we: we, word: word, addr: addr,
                   wdata: wdata};
      @(negedge mclk);
      bus_req <= {1'b0, ~bus_req[25:0]};
      while (bus_ack_q !== 1'b1 && n < 16) begin
         @(negedge mclk);
         n++;
      end
      rdata = bus_rdata_q;
      ok = (n < 16);
   endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                             mclk;
   logic                             nrst;
   tpu_pkg::tpu_req_s                bus_req;
   logic [15:0]                      bus_rdata_q;
   logic                             bus_ack_q;
   logic                             bus_busy_q;
   logic [tpu_pkg::NUM_CH-1:0]       run_q;
   logic [tpu_pkg::NUM_CH-1:0][15:0] count_q;
   logic                             ch1_pwm_q;
   logic                             ch2_pwm_q;
   logic [tpu_pkg::OE_CH1_W-1:0]     ch1_oe_q;
   logic [tpu_pkg::OE_CH2_W-1:0]     ch2_oe_q;
   int                               err_count = 0;
   int                               cmp_count = 0;
   logic [16:0]                      exp_q[$];
   logic [16:0]                      e;
   logic [31:0]                      rs = 32'h04bf_d102;
   logic [15:0]                      rd;
   logic [15:0]                      w;
   logic [15:0]                      k;
   logic [7:0]                       a;
   logic                             ok;
   tpu_ctl u_dut (.mclk(mclk), .nrst(nrst), .bus_req(bus_req),
      .bus_rdata_q(bus_rdata_q), .bus_ack_q(bus_ack_q),
      .bus_busy_q(bus_busy_q), .run_q(run_q), .count_q(count_q), .gr_q(),
      .dr_q(), .ch1_pwm_q(ch1_pwm_q), .ch2_pwm_q(ch2_pwm_q),
      .ch1_oe_q(ch1_oe_q), .ch2_oe_q(ch2_oe_q));
   tpu_cpu_model u_cpu (.mclk(mclk), .bus_req(bus_req),
      .bus_rdata_q(bus_rdata_q), .bus_ack_q(bus_ack_q));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compares=%0d errors=%0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Writes queue a note too, so every answer pops exactly one entry.
   task automatic acc(input logic we, input logic word, input logic [7:0] ad,
         input logic [15:0] wd, input logic [15:0] exp);
      exp_q.push_back({!we, exp});
      u_cpu.access(we, word, ad, wd, 0, rd, ok);
      if (!ok) begin
         err_count++;
         report_and_stop();
      end
   endtask
   always @(negedge mclk) begin
      if (nrst === 1'b1 && bus_ack_q === 1'b1) begin
         if (exp_q.size() == 0) begin
            err_count++;
         end else begin
            e = exp_q.pop_front();
            if (e[16]) chk(bus_rdata_q, e[15:0]);
         end
      end
   end
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      repeat (100000) @(posedge mclk);
      err_count++;
      report_and_stop();
   end
   initial begin
      nrst = 1'b0;
      repeat (4) @(negedge mclk);
      nrst <= 1'b1;
      acc(0, 0, tpu_pkg::OFS_RUN, 16'h0000, 16'h0080);
      acc(0, 0, tpu_pkg::OFS_MODE_B, 16'h0000, 16'h00C0);
      acc(0, 0, 8'h60, 16'h0000, 16'h0000);
      for (int c = 0; c < 7; c++) begin
         for (int b = 0; b < 3; b++) begin
            a = 8'h20 + 8'(b * 16 + 2 * c);
            rs = xs(rs);
            w = rs[15:0];
            acc(1, 1, a, w, 0);
            acc(1, 0, a | 8'h01, rs[31:16], 0);
            acc(0, 1, a, 0, {w[15:8], rs[23:16]});
            acc(0, 0, a, 0, {8'h00, w[15:8]});
         end
      end
      for (int p = 0; p < 3; p++) begin
         a = (p == 2) ? tpu_pkg::OFS_RUN : 8'(2 * p);
         k = (p == 2) ? 16'h8000 : 16'h0000;
         rs = xs(rs);
         w = rs[15:0];
         acc(1, 1, a, w, 0);
         acc(0, 0, a, 0, {8'h00, w[15:8] | k[15:8]});
         acc(0, 0, a + 8'h01, 0, {8'h00, w[7:0]});
         acc(0, 1, a, 0, w | k);
      end
      chk({9'h000, run_q}, {9'h000, w[14:8]});
      // Preload a nonzero count so the restart clear is visible.
      acc(1, 0, tpu_pkg::OFS_RUN, 16'h0000, 0);
      acc(1, 1, tpu_pkg::OFS_CNT_BASE, 16'h1234, 0);
      acc(1, 0, tpu_pkg::OFS_RUN, 16'h0001, 0);
      repeat (20) @(negedge mclk);
      acc(1, 0, tpu_pkg::OFS_RUN, 16'h0000, 0);
      repeat (3) @(negedge mclk);
      acc(0, 1, tpu_pkg::OFS_CNT_BASE, 0, 16'h0015);
      acc(1, 1, tpu_pkg::OFS_OE_CH1, 16'hFF00, 0);
      acc(1, 0, tpu_pkg::OFS_OE_CH2, 16'h00FF, 0);
      for (int m = 3; m >= 0; m--) begin
         acc(1, 0, tpu_pkg::OFS_MODE_B, 16'(m), 0);
         acc(0, 0, tpu_pkg::OFS_MODE_B, 0, 16'h00C0 | 16'(m));
         chk({15'h0000, ch1_pwm_q}, 16'(m & 1));
         chk({15'h0000, ch2_pwm_q}, 16'(m >> 1));
         chk({10'h000, ch1_oe_q}, m[0] ? 16'h0000 : 16'h003F);
         chk({12'h000, ch2_oe_q}, m[1] ? 16'h0000 : 16'h000F);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
